// ### bench/core_vr_startup_mode_sequencer_bench.sv
// self-checking bench of the regulator start-up and mode sequencer
module core_vr_startup_mode_sequencer_bench;
   timeunit 1ns;
   timeprecision 1ps;
   // short counts keep the run brief; every expectation uses these values
   localparam int START = 20;
   localparam int PGC = 50;
   logic hclk = 1'b0;
   logic hresetn, hsel, hwrite, hreadyout, hresp, rdy_q;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] haddr, hwdata, hrdata, rd_q, rd;
   logic cmd_on, cmd_wake_n, cmd_slow, cmd_fde, cmd_hot;
   logic [6:0] cmd_vid, vid;
   logic reg_on, wake_n, slow, fde, win, hot, pg_pin, alarm_pin;
   logic clk_en_n, pg_o, pg_oe, ta_o, ta_oe, ramp_active, irq;
   logic [13:0] target;
   vr_seq_pkg::mode_sel_t mode_sel;
   int mismatches = 0;
   int cmp_count = 0;
   int cyc = 0;
   int n;

   core_vr_startup_mode_sequencer #(.START_CYCLES(START), .PG_CYCLES(PGC))
      core_vr_startup_mode_sequencer_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
      .regulator_on(reg_on), .forced_diode_emul_en(fde), .deep_sleep_wake_n(wake_n),
      .deep_sleep_slow_slew(slow), .voltage_id_code(vid), .boot_window_ok(win),
      .thermistor_below_trip(hot), .clk_en_n(clk_en_n), .power_good_out_o(pg_o),
      .power_good_out_oe(pg_oe), .thermal_alarm_n_o(ta_o), .thermal_alarm_n_oe(ta_oe),
      .mode_sel(mode_sel), .ramp_active(ramp_active), .target_tenths_mv(target), .irq(irq));

   platform_pm_model platform_pm_model_inst (.hclk(hclk), .hresetn(hresetn), .cmd_on(cmd_on),
      .cmd_wake_n(cmd_wake_n), .cmd_slow(cmd_slow), .cmd_fde(cmd_fde), .cmd_hot(cmd_hot),
      .cmd_vid(cmd_vid), .ramp_active(ramp_active), .power_good_out_o(pg_o),
      .power_good_out_oe(pg_oe), .thermal_alarm_n_o(ta_o), .thermal_alarm_n_oe(ta_oe),
      .regulator_on(reg_on), .deep_sleep_wake_n(wake_n), .deep_sleep_slow_slew(slow),
      .forced_diode_emul_en(fde), .voltage_id_code(vid), .boot_window_ok(win),
      .thermistor_below_trip(hot), .pg_pin(pg_pin), .alarm_pin(alarm_pin));

   // ---------------------------------------------------------------
   // clock, bus sampling and hang guard
   // ---------------------------------------------------------------
   initial forever #2 hclk = ~hclk;
   // capture what the bus shows at each edge, before that edge's updates land
   always @(posedge hclk) begin
      rdy_q <= hreadyout;
      rd_q <= hrdata;
   end
   // a hung wait would otherwise never reach the verdict
   always @(posedge hclk) begin
      cyc++;
      if (cyc == 5000) begin
         mismatches++;
         $display("mismatch at %0t: run took too long", $time);
         test_done();
      end
   end

   // ---------------------------------------------------------------
   // shared tasks
   // ---------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      cmp_count++;
      if (seen !== want) begin
         mismatches++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask

   function automatic logic [31:0] exp_target(input logic [6:0] v);
      return {18'h0_0000, 14'h3A98 - 14'h007D * {7'h00, v}};
   endfunction

   // one single-word transfer; the master allows for wait states and waits for hready
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge hclk);
      #1;
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= {24'h00_0000, a};
      hwrite <= wr;
      hsize <= 3'b010;
      do begin @(posedge hclk); #1; end while (rdy_q !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      do begin @(posedge hclk); #1; end while (rdy_q !== 1'b1);
      rd = rd_q;
   endtask

   function automatic logic hit(input int w);
      case (w)
         0: return ramp_active === 1'b1;
         1: return win === 1'b1;
         2: return clk_en_n === 1'b0;
         default: return pg_oe === 1'b0;
      endcase
   endfunction

   // counts edges until the chosen event shows, bounded
   task automatic count_until(input int w);
      n = 0;
      while (!hit(w) && n < 2000) begin
         @(posedge hclk);
         #1;
         n++;
      end
   endtask

   task automatic settle(input int k);
      repeat (k) @(posedge hclk);
      #1;
   endtask

   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_regs();
      bus(1'b0, vr_seq_pkg::REG_CTRL, 32'h0000_0000);
      check(rd, 32'h0000_0001);
      bus(1'b0, vr_seq_pkg::REG_IRQ_MASK, 32'h0000_0000);
      check(rd, 32'h0000_0000);
      bus(1'b1, vr_seq_pkg::REG_TARGET, 32'h0000_1234);
      bus(1'b0, vr_seq_pkg::REG_TARGET, 32'h0000_0000);
      check(rd, 32'h0000_2EE0);
      bus(1'b0, 8'h14, 32'h0000_0000);
      check(rd, 32'h0000_0000);
      check({30'h0, hresp, pg_pin}, 32'h0000_0000);
      check({31'h0, clk_en_n}, 32'h0000_0001);
      $display("register test done");
   endtask

   // sleep and forced inputs are held active through start-up to show they are ignored
   task automatic t_start();
      cmd_vid <= 7'h25;
      cmd_wake_n <= 1'b0;
      cmd_fde <= 1'b1;
      cmd_slow <= 1'b1;
      cmd_on <= 1'b1;
      count_until(0);
      check({31'h0, n >= START && n <= START + 4}, 32'h0000_0001);
      check({27'h0, mode_sel}, 32'h0000_0010);
      count_until(1);
      count_until(2);
      check(n, 32'h0000_000E);
      check({27'h0, mode_sel}, 32'h0000_0011);
      check({18'h0, target}, exp_target(7'h25));
      count_until(3);
      check(n, PGC);
      check({30'h0, pg_pin, pg_o}, 32'h0000_0002);
      settle(2);
      check({27'h0, mode_sel}, 32'h0000_0006);
      $display("start-up test done");
   endtask

   task automatic t_modes();
      logic [2:0] ins [4] = '{3'b110, 3'b001, 3'b010, 3'b101};
      logic [4:0] want [4] = '{5'b10001, 5'b01000, 5'b00111, 5'b10000};
      logic [6:0] vids [4] = '{7'h00, 7'h01, 7'h40, 7'h60};
      for (int i = 0; i < 4; i++) begin
         {cmd_wake_n, cmd_fde, cmd_slow} <= ins[i];
         cmd_vid <= vids[i];
         settle(3);
         check({27'h0, mode_sel}, {27'h0, want[i]});
         check({18'h0, target}, exp_target(vids[i]));
      end
      $display("mode test done");
   endtask

   // raise with the mask off, unmask, then clear by writing ones
   task automatic t_irq();
      cmd_hot <= 1'b1;
      settle(3);
      check({30'h0, alarm_pin, ta_oe}, 32'h0000_0001);
      check({31'h0, irq}, 32'h0000_0000);
      bus(1'b0, vr_seq_pkg::REG_IRQ_STAT, 32'h0000_0000);
      check(rd, 32'h0000_0003);
      bus(1'b1, vr_seq_pkg::REG_IRQ_MASK, 32'h0000_0002);
      settle(2);
      check({31'h0, irq}, 32'h0000_0001);
      bus(1'b1, vr_seq_pkg::REG_IRQ_STAT, 32'h0000_0003);
      bus(1'b0, vr_seq_pkg::REG_IRQ_STAT, 32'h0000_0000);
      check(rd, 32'h0000_0000);
      check({31'h0, irq}, 32'h0000_0000);
      cmd_hot <= 1'b0;
      settle(3);
      check({30'h0, alarm_pin, ta_oe}, 32'h0000_0002);
      $display("interrupt test done");
   endtask

   task automatic t_abort();
      bus(1'b1, vr_seq_pkg::REG_IRQ_MASK, 32'h0000_0004);
      cmd_on <= 1'b0;
      settle(4);
      check({29'h0, clk_en_n, pg_oe, ramp_active}, 32'h0000_0006);
      check({26'h0, mode_sel, irq}, 32'h0000_0021);
      bus(1'b0, vr_seq_pkg::REG_STATUS, 32'h0000_0000);
      check(rd & 32'h0000_6007, 32'h0000_0000);
      cmd_on <= 1'b1;
      count_until(0);
      check({31'h0, ramp_active}, 32'h0000_0001);
      bus(1'b1, vr_seq_pkg::REG_CTRL, 32'h0000_0000);
      settle(2);
      check({30'h0, ramp_active, clk_en_n}, 32'h0000_0001);
      $display("abort test done");
   endtask

   task automatic test_done();
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // every input defined at time zero, reset held for twelve cycles
   initial begin
      hresetn = 1'b0;
      {hsel, hwrite, htrans, hsize, haddr, hwdata} = 70'h0;
      {cmd_on, cmd_wake_n, cmd_slow, cmd_fde, cmd_hot, cmd_vid} = 12'h020;
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      t_regs();
      t_start();
      t_modes();
      t_irq();
      t_abort();
      test_done();
   end
endmodule

// ### bench/platform_pm_model.sv
// platform power-management and analog comparator model facing the sequencer
module platform_pm_model #(
   parameter int RAMP_CYC = 30
) (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // commands from the bench
   input wire logic cmd_on,
   input wire logic cmd_wake_n,
   input wire logic cmd_slow,
   input wire logic cmd_fde,
   input wire logic cmd_hot,
   input wire logic [6:0] cmd_vid,
   // sequencer outputs seen by the platform
   input wire logic ramp_active,
   input wire logic power_good_out_o,
   input wire logic power_good_out_oe,
   input wire logic thermal_alarm_n_o,
   input wire logic thermal_alarm_n_oe,
   // lines driven toward the sequencer
   output logic regulator_on,
   output logic deep_sleep_wake_n,
   output logic deep_sleep_slow_slew,
   output logic forced_diode_emul_en,
   output logic [6:0] voltage_id_code,
   output logic boot_window_ok,
   output logic thermistor_below_trip,
   // resolved open-drain pins
   output logic pg_pin,
   output logic alarm_pin
);
   int ramp_cnt;
   // released pins float up to the external pull-ups
   assign pg_pin = power_good_out_oe ? power_good_out_o : 1'b1;
   assign alarm_pin = thermal_alarm_n_oe ? thermal_alarm_n_o : 1'b1;
   // platform levels hold a defined value from time zero
   initial begin
      {regulator_on, deep_sleep_wake_n, deep_sleep_slow_slew} = 3'h0;
      {forced_diode_emul_en, voltage_id_code, thermistor_below_trip} = 9'h000;
   end
   // platform lines change only just after an edge, never mid-cycle
   always @(posedge hclk) begin
      regulator_on <= cmd_on;
      deep_sleep_wake_n <= cmd_wake_n;
      deep_sleep_slow_slew <= cmd_slow;
      forced_diode_emul_en <= cmd_fde;
      voltage_id_code <= cmd_vid;
      thermistor_below_trip <= cmd_hot;
   end
   // the output reaches the boot window some time into the ramp, and loses it when idle
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ramp_cnt <= 0;
         boot_window_ok <= 1'b0;
      end else begin
         ramp_cnt <= ramp_active ? ramp_cnt + 1 : 0;
         boot_window_ok <= ramp_active && ramp_cnt >= RAMP_CYC;
      end
   end
endmodule

// ### design/core_vr_startup_mode_sequencer.sv
// start-up sequencer, mode selection and register slave of the core regulator
//
// Register access over AHB-Lite and the register offsets were left to the implementer.
module core_vr_startup_mode_sequencer #(
   parameter int START_CYCLES = vr_seq_pkg::START_DELAY_CYC,
   parameter int PG_CYCLES = vr_seq_pkg::PG_DELAY_CYC
) (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   // platform and processor controls
   input wire logic regulator_on,
   input wire logic forced_diode_emul_en,
   input wire logic deep_sleep_wake_n,
   input wire logic deep_sleep_slow_slew,
   input wire logic [6:0] voltage_id_code,
   // analog comparator results
   input wire logic boot_window_ok,
   input wire logic thermistor_below_trip,
   // outputs to the platform
   output logic clk_en_n,
   output logic power_good_out_o,
   output logic power_good_out_oe,
   output logic thermal_alarm_n_o,
   output logic thermal_alarm_n_oe,
   // controls to the analog modulator
   output vr_seq_pkg::mode_sel_t mode_sel,
   output logic ramp_active,
   output logic [13:0] target_tenths_mv,
   // interrupt
   output logic irq
);

   // ---------------------------------------------------------------
   // sequencer
   // ---------------------------------------------------------------
   vr_seq_pkg::seq_state_t state_q, state_d;
   logic [vr_seq_pkg::CNT_W-1:0] cnt_q, cnt_d;
   logic ctrl_en_q;
   logic enabled;
   logic start_done;

   // software may hold the regulator off, but can never turn it on alone
   assign enabled = regulator_on & ctrl_en_q;
   assign start_done = (state_q == vr_seq_pkg::ST_RUN);

   // next state; an abort from any state wins over progress
   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q + 1'b1;
      if (!enabled) begin
         state_d = vr_seq_pkg::ST_IDLE;
         cnt_d = '0;
      end else begin
         unique case (state_q)
            vr_seq_pkg::ST_IDLE: begin
               state_d = vr_seq_pkg::ST_DELAY;
               cnt_d = '0;
            end
            vr_seq_pkg::ST_DELAY: begin
               if (cnt_q == vr_seq_pkg::CNT_W'(START_CYCLES - 1)) begin
                  state_d = vr_seq_pkg::ST_RAMP;
                  cnt_d = '0;
               end
            end
            vr_seq_pkg::ST_RAMP: begin
               cnt_d = '0;
               if (boot_window_ok) begin
                  state_d = vr_seq_pkg::ST_COUNT;
               end
            end
            vr_seq_pkg::ST_COUNT: begin
               if (cnt_q == vr_seq_pkg::CNT_W'(vr_seq_pkg::CLKEN_COUNT_CYC - 1)) begin
                  state_d = vr_seq_pkg::ST_SLEW;
                  cnt_d = '0;
               end
            end
            vr_seq_pkg::ST_SLEW: begin
               if (cnt_q == vr_seq_pkg::CNT_W'(PG_CYCLES - 1)) begin
                  state_d = vr_seq_pkg::ST_RUN;
                  cnt_d = '0;
               end
            end
            vr_seq_pkg::ST_RUN: begin
               cnt_d = '0;
            end
            default: begin
               state_d = vr_seq_pkg::ST_IDLE;
               cnt_d = '0;
            end
         endcase
      end
   end

   // state and counter flops
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_q <= vr_seq_pkg::ST_IDLE;
         cnt_q <= '0;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
      end
   end

   // ---------------------------------------------------------------
   // mode selection and output decode
   // ---------------------------------------------------------------
   vr_seq_pkg::mode_sel_t mode_d;
   logic deeper_sleep;
   logic clk_en_n_d;
   logic [13:0] target_d;
   logic [13:0] vid_drop;

   // a low wake input is the deeper sleep state
   assign deeper_sleep = ~deep_sleep_wake_n;
   // binary code: each step lowers the target by 12.5 mV
   assign vid_drop = 14'(voltage_id_code * vr_seq_pkg::VID_STEP_TENTHS);
   assign clk_en_n_d = ~((state_d == vr_seq_pkg::ST_SLEW) | (state_d == vr_seq_pkg::ST_RUN));

   // until the sequence ends the sleep inputs are not looked at
   always_comb begin
      mode_d = '0;
      if (state_d == vr_seq_pkg::ST_RUN) begin
         mode_d.continuous_conduction = ~deeper_sleep;
         mode_d.diode_emulation = deeper_sleep & ~forced_diode_emul_en;
         mode_d.enhanced_diode_emulation = deeper_sleep & forced_diode_emul_en;
         mode_d.wide_window = deeper_sleep & forced_diode_emul_en;
         mode_d.soft_high_current = ~deep_sleep_slow_slew;
      end else begin
         mode_d.continuous_conduction = 1'b1;
         mode_d.soft_high_current = (state_d == vr_seq_pkg::ST_SLEW);
      end
   end

   // boot level while ramping, code target once the clock is enabled
   assign target_d = clk_en_n_d ? vr_seq_pkg::BOOT_TENTHS
      : vr_seq_pkg::VID_TOP_TENTHS - vid_drop;

   // every platform-facing enable is a flop and the pin data lines are tied low, so no decode glitch reaches a pin
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         clk_en_n <= 1'b1;
         mode_sel <= vr_seq_pkg::MODE_RESET;
         ramp_active <= 1'b0;
         target_tenths_mv <= vr_seq_pkg::BOOT_TENTHS;
         power_good_out_oe <= 1'b1;
         thermal_alarm_n_oe <= 1'b0;
      end else begin
         clk_en_n <= clk_en_n_d;
         mode_sel <= mode_d;
         ramp_active <= (state_d != vr_seq_pkg::ST_IDLE) & (state_d != vr_seq_pkg::ST_DELAY);
         target_tenths_mv <= target_d;
         power_good_out_oe <= (state_d != vr_seq_pkg::ST_RUN);
         thermal_alarm_n_oe <= thermistor_below_trip;
      end
   end

   // open-drain pins only ever drive low
   assign power_good_out_o = 1'b0;
   assign thermal_alarm_n_o = 1'b0;

   // ---------------------------------------------------------------
   // ahb-lite slave
   // ---------------------------------------------------------------
   logic wr_pend_q;
   logic [7:0] wr_addr_q;
   logic [2:0] irq_stat_q, irq_mask_q;
   logic [2:0] irq_set;
   logic addr_take;
   logic [31:0] rd_mux;
   logic pg_seen_q, therm_seen_q, run_seen_q;

   // a transfer is accepted only in a NONSEQ or SEQ address phase
   assign addr_take = hsel & hready & htrans[1];

   // read data is formed in the address phase and held in the data phase
   always_comb begin
      rd_mux = '0;
      unique case (haddr[7:0])
         vr_seq_pkg::REG_CTRL: rd_mux = {31'h0000_0000, ctrl_en_q};
         vr_seq_pkg::REG_STATUS: rd_mux = {9'h000, voltage_id_code, thermal_alarm_n_oe,
            ~power_good_out_oe, ~clk_en_n, mode_sel, 5'h00, state_q};
         vr_seq_pkg::REG_IRQ_STAT: rd_mux = {29'h0000_0000, irq_stat_q};
         vr_seq_pkg::REG_IRQ_MASK: rd_mux = {29'h0000_0000, irq_mask_q};
         vr_seq_pkg::REG_TARGET: rd_mux = {18'h0_0000, target_tenths_mv};
         default: rd_mux = '0;
      endcase
   end

   // zero-wait slave; unmapped addresses read zero and ignore writes
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         hrdata <= '0;
         wr_pend_q <= 1'b0;
         wr_addr_q <= '0;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         hrdata <= (addr_take & ~hwrite) ? rd_mux : '0;
         wr_pend_q <= addr_take & hwrite;
         wr_addr_q <= addr_take ? haddr[7:0] : wr_addr_q;
      end
   end

   // ---------------------------------------------------------------
   // control register and interrupts
   // ---------------------------------------------------------------
   // events: power good rise, thermal alarm rise, abort of a running sequence
   assign irq_set[vr_seq_pkg::IRQ_PG_RISE] = ~power_good_out_oe & ~pg_seen_q;
   assign irq_set[vr_seq_pkg::IRQ_THERMAL] = thermal_alarm_n_oe & ~therm_seen_q;
   assign irq_set[vr_seq_pkg::IRQ_ABORT] = run_seen_q & (state_q == vr_seq_pkg::ST_IDLE);

   // write-one-to-clear; a set in the same cycle survives the clear
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_en_q <= vr_seq_pkg::CTRL_RESET;
         irq_mask_q <= vr_seq_pkg::IRQ_MASK_RESET;
         irq_stat_q <= '0;
         irq <= 1'b0;
         pg_seen_q <= 1'b0;
         therm_seen_q <= 1'b0;
         run_seen_q <= 1'b0;
      end else begin
         if (wr_pend_q && wr_addr_q == vr_seq_pkg::REG_CTRL) begin
            ctrl_en_q <= hwdata[0];
         end
         if (wr_pend_q && wr_addr_q == vr_seq_pkg::REG_IRQ_MASK) begin
            irq_mask_q <= hwdata[2:0];
         end
         if (wr_pend_q && wr_addr_q == vr_seq_pkg::REG_IRQ_STAT) begin
            irq_stat_q <= (irq_stat_q & ~hwdata[2:0]) | irq_set;
         end else begin
            irq_stat_q <= irq_stat_q | irq_set;
         end
         irq <= |(irq_stat_q & irq_mask_q);
         pg_seen_q <= ~power_good_out_oe;
         therm_seen_q <= thermal_alarm_n_oe;
         run_seen_q <= (state_q != vr_seq_pkg::ST_IDLE);
      end
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   logic [vr_seq_pkg::CNT_W-1:0] pg_wait_q;
   logic [4:0] count_cyc_q;

   // cycles spent counting inside the boot window; a counter keeps the check cheap to unroll
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         count_cyc_q <= '0;
      end else begin
         count_cyc_q <= (state_q == vr_seq_pkg::ST_COUNT) ? count_cyc_q + 1'b1 : '0;
      end
   end

   // cycles since clock enable went active, for the power-good delay check
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pg_wait_q <= '0;
      end else begin
         pg_wait_q <= clk_en_n ? '0 : pg_wait_q + 1'b1;
      end
   end

   pg_delay_a: assert property (@(posedge hclk) disable iff (!hresetn)
      $fell(power_good_out_oe) |-> pg_wait_q == vr_seq_pkg::CNT_W'(PG_CYCLES))
      else $error("power good delay off");
   clken_count_a: assert property (@(posedge hclk) disable iff (!hresetn)
      $fell(clk_en_n) |-> count_cyc_q == 5'(vr_seq_pkg::CLKEN_COUNT_CYC))
      else $error("clock enable not after 13 cycles");
   start_delay_a: assert property (@(posedge hclk) disable iff (!hresetn)
      $rose(ramp_active) |-> $past(state_q) == vr_seq_pkg::ST_DELAY)
      else $error("ramp started without delay");
   abort_idle_a: assert property (@(posedge hclk) disable iff (!hresetn)
      !regulator_on |=> clk_en_n && power_good_out_oe && state_q == vr_seq_pkg::ST_IDLE)
      else $error("abort did not drop outputs");
   startup_ccm_a: assert property (@(posedge hclk) disable iff (!hresetn)
      power_good_out_oe |-> mode_sel.continuous_conduction && !mode_sel.diode_emulation)
      else $error("left conduction mode during start-up");
   soft_current_a: assert property (@(posedge hclk) disable iff (!hresetn)
      $fell(clk_en_n) |-> mode_sel.soft_high_current)
      else $error("soft current not raised at clock enable");
   ramp_low_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (ramp_active && clk_en_n) |-> !mode_sel.soft_high_current)
      else $error("boot ramp not on low current");
   forced_dem_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (state_q == vr_seq_pkg::ST_RUN && enabled && !deep_sleep_wake_n && forced_diode_emul_en)
      |=> mode_sel.wide_window && mode_sel.enhanced_diode_emulation)
      else $error("forced diode emulation not applied");
   thermal_pin_a: assert property (@(posedge hclk) disable iff (!hresetn)
      thermistor_below_trip |=> thermal_alarm_n_oe && !thermal_alarm_n_o)
      else $error("thermal alarm not pulled low");
   vid_target_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (!clk_en_n && $stable(voltage_id_code) && $stable(clk_en_n))
      |-> target_tenths_mv == 14'(15000 - 125 * voltage_id_code))
      else $error("target does not follow code");
   pg_open_a: assert property (@(posedge hclk) disable iff (!hresetn)
      power_good_out_oe != start_done)
      else $error("power good pin not released at end of start-up");
   awake_ccm_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (state_q == vr_seq_pkg::ST_RUN && enabled && deep_sleep_wake_n)
      |=> mode_sel.continuous_conduction && !mode_sel.diode_emulation)
      else $error("awake core not in conduction mode");
   slow_slew_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (state_q == vr_seq_pkg::ST_RUN && enabled && deep_sleep_slow_slew)
      |=> !mode_sel.soft_high_current)
      else $error("slow slew not on low current");
   irq_level_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (|(irq_stat_q & irq_mask_q)) |=> irq)
      else $error("unmasked event did not raise interrupt");

endmodule

// ### design/vr_seq_pkg.sv
// shared constants and types of the core regulator start-up and mode sequencer
package vr_seq_pkg;

   // ---------------------------------------------------------------
   // clock and timing
   // ---------------------------------------------------------------
   localparam int CLK_MHZ = 250;
   localparam int START_DELAY_US = 100;   // enable to start of soft-start ramp
   localparam int START_DELAY_CYC = START_DELAY_US * CLK_MHZ;
   localparam int PG_DELAY_US = 6800;     // clock enable to power good, nominal
   localparam int PG_MIN_US = 5500;
   localparam int PG_MAX_US = 8100;
   localparam int PG_DELAY_CYC = PG_DELAY_US * CLK_MHZ;
   localparam int CLKEN_COUNT_CYC = 13;   // cycles inside boot window before clock enable
   localparam int CNT_W = 21;

   // ---------------------------------------------------------------
   // voltage targets, units of 0.1 mV
   // ---------------------------------------------------------------
   localparam logic [13:0] VID_TOP_TENTHS = 14'h3A98;  // 1.5 V
   localparam logic [13:0] VID_STEP_TENTHS = 14'h007D; // 12.5 mV
   localparam logic [13:0] BOOT_TENTHS = 14'h2EE0;     // 1.2 V

   // ---------------------------------------------------------------
   // register map, byte addresses
   // ---------------------------------------------------------------
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_IRQ_STAT = 8'h08;
   localparam logic [7:0] REG_IRQ_MASK = 8'h0C;
   localparam logic [7:0] REG_TARGET = 8'h10;
   localparam logic [0:0] CTRL_RESET = 1'h1;
   localparam int IRQ_W = 3;
   localparam int IRQ_PG_RISE = 0;
   localparam int IRQ_THERMAL = 1;
   localparam int IRQ_ABORT = 2;
   localparam logic [2:0] IRQ_MASK_RESET = 3'h0;

   // ---------------------------------------------------------------
   // sequencer states, gray along the start-up path
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_DELAY = 3'h1,
      ST_RAMP = 3'h3,
      ST_COUNT = 3'h2,
      ST_SLEW = 3'h6,
      ST_RUN = 3'h7
   } seq_state_t;

   // modulator mode selection bundle
   typedef struct packed {
      logic continuous_conduction;
      logic diode_emulation;
      logic enhanced_diode_emulation;
      logic wide_window;
      logic soft_high_current;
   } mode_sel_t;

   // idle and reset sit in continuous conduction, the same as start-up
   localparam mode_sel_t MODE_RESET = mode_sel_t'(5'h10);

endpackage
